// ==== verilog/rfi_pkg.sv ====
// constants, field layout and timing tables for the rom/flash interface
// assumes one memory clock equal to REF_CLK and a classic wishbone register bus
//
// Functional notes
// - chip select only for 0x00000000..0x01ffffff
// - full-speed bit zero doubles every timing
// - writes off at reset; then no strobes
// - output enable still strobed on reads
// - non-sequential code 000..101 gives 7..2 cycles
// - burst code 00 off, 01..11 gives 4..2
// - burst reads step low address bits, four max
// - a write cycle lasts at least three cycles
// - 16-bit no burst: two non-sequential halves
// - 16-bit read with burst: second half uses burst
// - 16-bit bank shifts address; half on line 2
// - lower address half lands in bits 15..0
// - bank config bytes at 0x03200080 and 0x03200084
// - width bit: 0 is 32-bit, 1 16-bit
// - config registers reset to 0x40
// - config reads return last written values
// - read and write strobes reuse io strobe pins
package rfi_pkg;

    // --------------------------------------------------------------
    // address map
    // --------------------------------------------------------------
    localparam logic [31:0] ROM_SPACE_LAST  = 32'h01ffffff;
    localparam logic [31:0] BANK0_CFG_ADDR  = 32'h03200080;
    localparam logic [31:0] BANK1_CFG_ADDR  = 32'h03200084;
    localparam int          BANK_SEL_BIT    = 24;

    // --------------------------------------------------------------
    // configuration byte
    // --------------------------------------------------------------
    typedef struct packed {
        logic       write_allow;    // bit 7
        logic       width16;        // bit 6
        logic       full_speed;     // bit 5
        logic [1:0] burst_time;     // bits 4:3
        logic [2:0] nonseq_time;    // bits 2:0
    } rfi_cfg_t;

    localparam logic [7:0] CFG_RESET = 8'h40;

    // --------------------------------------------------------------
    // timing counts in memory clock cycles
    // --------------------------------------------------------------
    localparam logic [3:0] NONSEQ_SLOWEST  = 4'h7;
    localparam logic [3:0] NONSEQ_FASTEST  = 4'h2;
    localparam logic [2:0] NONSEQ_LAST_DEF = 3'h5;
    localparam logic [3:0] BURST_SLOWEST   = 4'h4;
    localparam logic [3:0] WRITE_MIN_CYC   = 4'h3;

    typedef enum logic [1:0] {
        RFI_IDLE   = 2'b00,
        RFI_STROBE = 2'b01,
        RFI_GAP    = 2'b10,
        RFI_ACK    = 2'b11
    } rfi_state_t;

endpackage : rfi_pkg

// ==== verilog/rfi_rom_flash.sv ====
// rom/flash interface: wishbone slave in front, two rom banks behind
// assumes wishbone classic master on REF_CLK and rom pins sampled on REF_CLK
`timescale 1ns/1ns

module rfi_rom_flash #(
    parameter int LA_W = 26
) (
    // clock and reset
    input  wire logic              REF_CLK,
    input  wire logic              RST,
    // wishbone slave
    input  wire logic              WB_CYC_I,
    input  wire logic              WB_STB_I,
    input  wire logic              WB_WE_I,
    input  wire logic [31:0]       WB_ADR_I,
    input  wire logic [3:0]        WB_SEL_I,
    input  wire logic [31:0]       WB_DAT_I,
    output logic      [31:0]       WB_DAT_O,
    output logic                   WB_ACK_O,
    // rom pins
    output logic                   ROM_CHIP_SELECT_N,
    output logic                   IO_READ_STROBE_N,
    output logic                   IO_WRITE_STROBE_N,
    output logic      [LA_W-1:0]   LATCHED_ADDRESS,
    input  wire logic [31:0]       ROM_DATA_I,
    output logic      [31:0]       ROM_DATA_O,
    output logic                   ROM_DATA_OE
);

    // --------------------------------------------------------------
    // timing helpers
    // --------------------------------------------------------------
    function automatic logic [3:0] scale(input logic [3:0] cyc, input logic full);
        scale = full ? cyc : 4'(cyc << 1);
    endfunction : scale

    function automatic logic [3:0] nonseq_len(input rfi_pkg::rfi_cfg_t c);
        logic [3:0] base;
        if (c.nonseq_time > rfi_pkg::NONSEQ_LAST_DEF) begin
            base = rfi_pkg::NONSEQ_FASTEST;
        end else begin
            base = rfi_pkg::NONSEQ_SLOWEST - {1'b0, c.nonseq_time};
        end
        nonseq_len = scale(base, c.full_speed);
    endfunction : nonseq_len

    function automatic logic [3:0] burst_len(input rfi_pkg::rfi_cfg_t c);
        logic [3:0] base;
        base = rfi_pkg::BURST_SLOWEST + 4'h1 - {2'b00, c.burst_time};
        burst_len = scale(base, c.full_speed);
    endfunction : burst_len

    function automatic logic [3:0] write_len(input logic [3:0] cyc);
        write_len = (cyc < rfi_pkg::WRITE_MIN_CYC) ? rfi_pkg::WRITE_MIN_CYC : cyc;
    endfunction : write_len

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    rfi_pkg::rfi_state_t state_reg;
    rfi_pkg::rfi_cfg_t   cfg0_reg;
    rfi_pkg::rfi_cfg_t   cfg1_reg;
    logic [3:0]          count_reg;
    logic [3:0]          second_len_reg;
    logic                half_reg;
    logic                is_write_reg;
    logic                wide16_reg;
    logic [15:0]         low_half_reg;
    logic [31:0]         wdata_reg;
    logic                burst_live_reg;
    logic [24:4]         burst_base_reg;
    logic [1:0]          burst_next_reg;

    // --------------------------------------------------------------
    // request decode
    // --------------------------------------------------------------
    logic               req;
    logic               hit_rom;
    logic               hit_cfg0;
    logic               hit_cfg1;
    rfi_pkg::rfi_cfg_t  bank_cfg;
    logic               burst_on;
    logic               seq_hit;
    logic [3:0]         first_len;
    logic [3:0]         next_len;
    logic [LA_W-1:0]    la_first;

    assign req      = WB_CYC_I && WB_STB_I && !WB_ACK_O && state_reg == rfi_pkg::RFI_IDLE;
    assign hit_rom  = WB_ADR_I <= rfi_pkg::ROM_SPACE_LAST;
    assign hit_cfg0 = WB_ADR_I == rfi_pkg::BANK0_CFG_ADDR;
    assign hit_cfg1 = WB_ADR_I == rfi_pkg::BANK1_CFG_ADDR;
    assign bank_cfg = WB_ADR_I[rfi_pkg::BANK_SEL_BIT] ? cfg1_reg : cfg0_reg;
    assign burst_on = bank_cfg.burst_time != 2'b00;

    // a read continues a burst when it is the next word of the same quad
    assign seq_hit = burst_live_reg && burst_on && !WB_WE_I
                     && WB_ADR_I[24:4] == burst_base_reg
                     && WB_ADR_I[3:2] == burst_next_reg;

    always_comb begin
        if (WB_WE_I) begin
            first_len = write_len(nonseq_len(bank_cfg));
            next_len  = write_len(nonseq_len(bank_cfg));
        end else begin
            first_len = seq_hit ? burst_len(bank_cfg) : nonseq_len(bank_cfg);
            next_len  = burst_on ? burst_len(bank_cfg) : nonseq_len(bank_cfg);
        end
    end

    // 16-bit banks move the word address up one place; the half index is line 2
    always_comb begin
        if (bank_cfg.width16) begin
            la_first = LA_W'({WB_ADR_I[24:2], 1'b0, WB_ADR_I[1:0]});
        end else begin
            la_first = LA_W'(WB_ADR_I[24:0]);
        end
    end

    // --------------------------------------------------------------
    // configuration registers
    // --------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            cfg0_reg <= rfi_pkg::CFG_RESET;
            cfg1_reg <= rfi_pkg::CFG_RESET;
        end else if (req && WB_WE_I && WB_SEL_I[0]) begin
            if (hit_cfg0) begin
                cfg0_reg <= WB_DAT_I[7:0];
            end
            if (hit_cfg1) begin
                cfg1_reg <= WB_DAT_I[7:0];
            end
        end
    end

    // --------------------------------------------------------------
    // burst tracking
    // --------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            burst_live_reg <= 1'b0;
            burst_base_reg <= '0;
            burst_next_reg <= 2'h0;
        end else if (req) begin
            if (hit_rom && !WB_WE_I) begin
                // the quad ends after the fourth word
                burst_live_reg <= WB_ADR_I[3:2] != 2'h3;
                burst_base_reg <= WB_ADR_I[24:4];
                burst_next_reg <= WB_ADR_I[3:2] + 2'h1;
            end else if (WB_WE_I) begin
                burst_live_reg <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------
    // access sequencer
    // --------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state_reg         <= rfi_pkg::RFI_IDLE;
            count_reg         <= 4'h0;
            second_len_reg    <= 4'h0;
            half_reg          <= 1'b0;
            is_write_reg      <= 1'b0;
            wide16_reg        <= 1'b0;
            low_half_reg      <= 16'h0000;
            wdata_reg         <= 32'h00000000;
            WB_ACK_O          <= 1'b0;
            WB_DAT_O          <= 32'h00000000;
            ROM_CHIP_SELECT_N <= 1'b1;
            IO_READ_STROBE_N  <= 1'b1;
            IO_WRITE_STROBE_N <= 1'b1;
            LATCHED_ADDRESS   <= '0;
            ROM_DATA_O        <= 32'h00000000;
            ROM_DATA_OE       <= 1'b0;
        end else begin
            case (state_reg)
                rfi_pkg::RFI_IDLE: begin
                    if (req) begin
                        is_write_reg   <= WB_WE_I;
                        wide16_reg     <= bank_cfg.width16;
                        wdata_reg      <= WB_DAT_I;
                        second_len_reg <= next_len - 4'h1;
                        half_reg       <= 1'b0;
                        if (hit_rom && (!WB_WE_I || bank_cfg.write_allow)) begin
                            ROM_CHIP_SELECT_N <= 1'b0;
                            IO_READ_STROBE_N  <= WB_WE_I;
                            IO_WRITE_STROBE_N <= !WB_WE_I;
                            LATCHED_ADDRESS   <= la_first;
                            ROM_DATA_OE       <= WB_WE_I;
                            ROM_DATA_O        <= bank_cfg.width16
                                                 ? {16'h0000, WB_DAT_I[15:0]} : WB_DAT_I;
                            count_reg         <= first_len - 4'h1;
                            state_reg         <= rfi_pkg::RFI_STROBE;
                        end else begin
                            // config, unmapped, or rom write while writes are off
                            WB_DAT_O  <= hit_cfg0 ? {24'h000000, cfg0_reg}
                                       : hit_cfg1 ? {24'h000000, cfg1_reg}
                                       : 32'h00000000;
                            WB_ACK_O  <= 1'b1;
                            state_reg <= rfi_pkg::RFI_ACK;
                        end
                    end
                end
                rfi_pkg::RFI_STROBE: begin
                    if (count_reg != 4'h0) begin
                        count_reg <= count_reg - 4'h1;
                    end else if (wide16_reg && !half_reg) begin
                        // first half done: hold it, release strobes one cycle
                        low_half_reg      <= ROM_DATA_I[15:0];
                        IO_READ_STROBE_N  <= 1'b1;
                        IO_WRITE_STROBE_N <= 1'b1;
                        half_reg          <= 1'b1;
                        LATCHED_ADDRESS[2] <= 1'b1;
                        ROM_DATA_O        <= {16'h0000, wdata_reg[31:16]};
                        state_reg         <= rfi_pkg::RFI_GAP;
                    end else begin
                        WB_DAT_O          <= wide16_reg
                                             ? {ROM_DATA_I[15:0], low_half_reg}
                                             : ROM_DATA_I;
                        ROM_CHIP_SELECT_N <= 1'b1;
                        IO_READ_STROBE_N  <= 1'b1;
                        IO_WRITE_STROBE_N <= 1'b1;
                        ROM_DATA_OE       <= 1'b0;
                        WB_ACK_O          <= 1'b1;
                        state_reg         <= rfi_pkg::RFI_ACK;
                    end
                end
                rfi_pkg::RFI_GAP: begin
                    IO_READ_STROBE_N  <= is_write_reg;
                    IO_WRITE_STROBE_N <= !is_write_reg;
                    count_reg         <= second_len_reg;
                    state_reg         <= rfi_pkg::RFI_STROBE;
                end
                rfi_pkg::RFI_ACK: begin
                    WB_ACK_O  <= 1'b0;
                    state_reg <= rfi_pkg::RFI_IDLE;
                end
                default: begin
                    state_reg <= rfi_pkg::RFI_IDLE;
                end
            endcase
        end
    end

endmodule : rfi_rom_flash

// ==== tb/rfi_rom_flash_properties.sv ====
// port checker for the rom/flash interface
// assumes it is bound onto rfi_rom_flash, one clock domain
`timescale 1ns/1ns
module rfi_rom_flash_properties (
    // clock and reset
    input wire logic        REF_CLK,
    input wire logic        RST,
    // register bus
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [31:0] WB_ADR_I,
    input wire logic        WB_ACK_O,
    // rom pins
    input wire logic        ROM_CHIP_SELECT_N,
    input wire logic        IO_READ_STROBE_N,
    input wire logic        IO_WRITE_STROBE_N,
    input wire logic        ROM_DATA_OE
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    // ------------------------------------------------------------
    // sequences and assertions
    // ------------------------------------------------------------
    sequence s_req;
        $rose(WB_STB_I) && WB_CYC_I;
    endsequence
    sequence s_cfg_req;
        s_req ##0 (WB_ADR_I == rfi_pkg::BANK0_CFG_ADDR || WB_ADR_I == rfi_pkg::BANK1_CFG_ADDR);
    endsequence
    sequence s_rom_req;
        s_req ##0 (WB_ADR_I <= rfi_pkg::ROM_SPACE_LAST);
    endsequence
    AST_CS_RANGE: assert property (!ROM_CHIP_SELECT_N |-> WB_CYC_I && WB_ADR_I <= rfi_pkg::ROM_SPACE_LAST)
        else $error("chip select outside rom space");
    AST_OE_READ: assert property (!IO_READ_STROBE_N |-> !ROM_CHIP_SELECT_N && !WB_WE_I)
        else $error("output enable outside a rom read");
    AST_WE_WRITE: assert property (!IO_WRITE_STROBE_N |-> !ROM_CHIP_SELECT_N && WB_WE_I)
        else $error("write strobe outside a rom write");
    AST_DRIVE_WRITE: assert property (ROM_DATA_OE |-> WB_CYC_I && WB_WE_I && !ROM_CHIP_SELECT_N)
        else $error("data driven outside a rom write");
    AST_WRITE_MIN: assert property ($fell(IO_WRITE_STROBE_N) |-> !IO_WRITE_STROBE_N [*3])
        else $error("write strobe shorter than three cycles");
    AST_READ_MIN: assert property ($fell(IO_READ_STROBE_N) |-> !IO_READ_STROBE_N [*2])
        else $error("read strobe shorter than two cycles");
    AST_CFG_ACK: assert property (s_cfg_req |-> ##[1:2] WB_ACK_O)
        else $error("config access not acknowledged");
    AST_ROM_ACK: assert property (s_rom_req |-> ##[1:40] WB_ACK_O)
        else $error("rom access not acknowledged in time");
endmodule : rfi_rom_flash_properties

bind rfi_rom_flash rfi_rom_flash_properties u_props (
    .REF_CLK(REF_CLK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_ACK_O(WB_ACK_O),
    .ROM_CHIP_SELECT_N(ROM_CHIP_SELECT_N), .IO_READ_STROBE_N(IO_READ_STROBE_N),
    .IO_WRITE_STROBE_N(IO_WRITE_STROBE_N), .ROM_DATA_OE(ROM_DATA_OE)
);

// ==== tb/rfi_rom_model.sv ====
// word-wide rom/flash memory behind the rom pins
// assumes pins sampled on the rising clock; data lines float when unselected
`timescale 1ns/1ns
module rfi_rom_model #(
    parameter int LA_W = 26
) (
    // clock and pins
    input  wire logic            clk,
    input  wire logic            cs_n,
    input  wire logic            oe_n,
    input  wire logic            we_n,
    input  wire logic [LA_W-1:0] la,
    input  wire logic [31:0]     wdata,
    input  wire logic            wdata_oe,
    output logic      [31:0]     rdata
);
    logic [31:0] mem [int];
    logic [31:0] last_reg = 32'h0;
    // whole word stored; byte lanes would need an outside decode of la[1:0]
    always @(posedge clk) begin
        if (!cs_n && !we_n && wdata_oe) begin
            mem[int'(la)] = wdata;
        end
        if (!cs_n && !oe_n) begin
            last_reg <= rdata;
        end
    end
    // floating lines show the inverse of the last value
    always @* begin
        if (!cs_n && !oe_n) begin
            rdata = mem.exists(int'(la)) ? mem[int'(la)] : {6'h00, la} ^ 32'h5a5a0000;
        end else begin
            rdata = ~last_reg;
        end
    end
endmodule : rfi_rom_model

// ==== tb/rfi_rom_flash_tb.sv ====
// self-checking bench for rfi_rom_flash
// assumes rfi_rom_model on the rom pins and the bound port checker
`timescale 1ns/1ns
module rfi_rom_flash_tb;
    logic        ref_clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [31:0] adr = 32'h0, wdat = 32'h0, lfsr = 32'h3577, rdat, rom_i, rom_o, rd;
    logic        ack, cs_n, oe_n, we_n, doe;
    logic [25:0] la;
    logic [31:0] exp_mem [int];
    int          error_cnt = 0, n_tests = 0, oe_cnt = 0, we_cnt = 0, oe_d, we_d;
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        oe_cnt <= oe_cnt + int'(!oe_n);
        we_cnt <= we_cnt + int'(!we_n);
    end
    rfi_rom_flash dut (.REF_CLK(ref_clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .ROM_CHIP_SELECT_N(cs_n), .IO_READ_STROBE_N(oe_n),
        .IO_WRITE_STROBE_N(we_n), .LATCHED_ADDRESS(la), .ROM_DATA_I(rom_i),
        .ROM_DATA_O(rom_o), .ROM_DATA_OE(doe));
    rfi_rom_model u_rom (.clk(ref_clk), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .la(la),
        .wdata(rom_o), .wdata_oe(doe), .rdata(rom_i));
    function automatic logic [31:0] word_at(input logic [25:0] a);
        return exp_mem.exists(int'(a)) ? exp_mem[int'(a)] : {6'h00, a} ^ 32'h5a5a0000;
    endfunction : word_at
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    function automatic logic [31:0] exp16(input logic [31:0] a);
        logic [31:0] lo, hi;
        lo = word_at({a[24:2], 1'b0, a[1:0]});
        hi = word_at({a[24:2], 1'b1, a[1:0]});
        return {hi[15:0], lo[15:0]};
    endfunction : exp16
    function automatic int nlen(input logic [7:0] c);
        int n;
        n = (c[2:0] > 3'h5) ? 2 : 7 - int'(c[2:0]);
        return c[5] ? n : 2 * n;
    endfunction : nlen
    function automatic int blen(input logic [7:0] c);
        return (c[5] ? 1 : 2) * (5 - int'(c[4:3]));
    endfunction : blen
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int c, o0, w0;
        o0 = oe_cnt;
        w0 = we_cnt;
        c = 0;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge ref_clk);
            c++;
        end while (ack !== 1'b1 && c < 100);
        if (ack !== 1'b1) begin
            error_cnt++;
            $display("CHECK FAILED ack expected 1 seen %b", ack);
        end
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        oe_d = oe_cnt - o0;
        we_d = we_cnt - w0;
    endtask : wb
    task automatic results;
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        results();
    end
    initial begin
        logic [7:0]  cfg;
        logic [31:0] a;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        wb(1'b0, rfi_pkg::BANK1_CFG_ADDR, 32'h0);
        chk("cfg1 reset", {24'h0, rfi_pkg::CFG_RESET}, rd);
        wb(1'b0, 32'h03200088, 32'h0);
        chk("unmapped", 32'h0, rd);
        wb(1'b0, 32'h00000126, 32'h0);
        chk("rd16 data", exp16(32'h126), rd);
        chk("rd16 oe", 32'd28, oe_d);
        wb(1'b1, 32'h00000126, lfsr);
        chk("locked we", 32'd0, we_d);
        wb(1'b1, rfi_pkg::BANK0_CFG_ADDR, lfsr);
        wb(1'b0, rfi_pkg::BANK0_CFG_ADDR, 32'h0);
        chk("cfg0 readback", {24'h0, lfsr[7:0]}, rd);
        for (int i = 0; i < 16; i++) begin
            cfg = {2'b00, i[3], 2'b00, i[2:0]};
            wb(1'b1, rfi_pkg::BANK1_CFG_ADDR, {24'h0, cfg});
            lfsr = lfsr_next(lfsr);
            a = {7'h00, 1'b1, lfsr[23:2], 2'b00};
            wb(1'b0, a, 32'h0);
            chk("rd32 data", word_at({1'b0, a[24:0]}), rd);
            chk("rd32 oe", nlen(cfg), oe_d);
        end
        for (int b = 1; b < 4; b++) begin
            cfg = {3'b001, b[1:0], 3'h0};
            wb(1'b1, rfi_pkg::BANK0_CFG_ADDR, {24'h0, cfg});
            for (int k = 0; k < 4; k++) begin
                wb(1'b0, 32'h40 + 4 * k, 32'h0);
                chk("burst data", word_at(26'h40 + 26'(4 * k)), rd);
                chk("burst oe", k == 0 ? nlen(cfg) : blen(cfg), oe_d);
            end
        end
        wb(1'b1, rfi_pkg::BANK0_CFG_ADDR, 32'h7c);
        wb(1'b0, 32'h00000208, 32'h0);
        chk("rd16 burst data", exp16(32'h208), rd);
        chk("rd16 burst oe", 32'd5, oe_d);
        for (int i = 0; i < 2; i++) begin
            cfg = i ? 8'h80 : 8'ha5;
            wb(1'b1, rfi_pkg::BANK1_CFG_ADDR, {24'h0, cfg});
            lfsr = lfsr_next(lfsr);
            a = 32'h01000300 + 4 * i;
            wb(1'b1, a, lfsr);
            exp_mem[int'({1'b0, a[24:0]})] = lfsr;
            chk("write we", nlen(cfg) < 3 ? 3 : nlen(cfg), we_d);
            wb(1'b0, a, 32'h0);
            chk("readback", word_at({1'b0, a[24:0]}), rd);
        end
        results();
    end
endmodule : rfi_rom_flash_tb
